// File: i2c_setup_defs.svh
// Register indexes, field positions and reset values of the I2C setup block
`ifndef I2C_SETUP_DEFS_SVH
`define I2C_SETUP_DEFS_SVH
`define APB_ADDR_W 12
`define CSD_IDX 10'h0E2
`define TAR_IDX 10'h0E9
`define TCR_IDX 10'h0EA
`define CST_IDX 10'h0E4
`define CSD_RST 8'h00
`define TAR_RST 8'hC8
`define TCR_RST 8'h04
`define CST_RST 8'h00
`define OWN_ADDR_RST 7'h64
`define TAR_EN_BIT 0
`define CTRL_IE_BIT 7
`define TX_IE_BIT 6
`define RX2_IE_BIT 5
`define RX1_IE_BIT 4
`define TX_FLAG_BIT 2
`define RX2_FLAG_BIT 1
`define RX1_FLAG_BIT 0
`define CTRL_FLAG_BIT 0
`define FIFO_DEPTH 4
`endif

// File: i2c_setup_pkg.sv
// Types shared by the I2C setup block
package i2c_setup_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [31:0] word_t;
    typedef logic [11:0] apb_addr_t;
endpackage

// File: byte_fifo_if.sv
// Valid/ready carrier between the setup block and its byte FIFO
interface byte_fifo_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] in_data;
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] out_data;
    logic out_valid;
    logic out_ready;
    modport fifo (input in_data, input in_valid, output in_ready,
                  output out_data, output out_valid, input out_ready);
    modport user (output in_data, output in_valid, input in_ready,
                  input out_data, input out_valid, output out_ready);
endinterface

// File: byte_fifo.sv
// Flip-flop FIFO with registered ready and valid flags
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    byte_fifo_if.fifo port
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic space, next_space, avail, next_avail;
    logic push, pop;

    always_comb
    begin
        push = port.in_valid && space;
        pop = port.out_ready && avail;
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        next_space = next_count != (AW+1)'(DEPTH);
        next_avail = next_count != '0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            space <= 1'b1;
            avail <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            space <= next_space;
            avail <= next_avail;
        end
    end

    // Storage needs no reset; valid gates every read of it
    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr] <= port.in_data;
    end

    assign port.in_ready = space;
    assign port.out_valid = avail;
    assign port.out_data = mem[rd_ptr];
endmodule // byte_fifo

// File: i2c_setup.sv
// APB register block: controller shift data, target address and interrupt setup
`include "i2c_setup_defs.svh"
module i2c_setup (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire i2c_setup_pkg::apb_addr_t paddr,
    input wire i2c_setup_pkg::word_t pwdata,
    output logic pready,
    output i2c_setup_pkg::word_t prdata,
    output logic pslverr,
    input wire logic transfer_open,
    input wire logic ctrl_byte_done,
    input wire logic tgt_tx_done,
    input wire logic tgt_rx_second_done,
    input wire logic tgt_rx_first_done,
    input wire i2c_setup_pkg::byte_t rx_byte,
    input wire logic rx_byte_valid,
    output logic rx_byte_ready,
    output i2c_setup_pkg::byte_t tx_byte,
    output logic resume_tx,
    output logic resume_rx,
    output logic [6:0] own_target_address,
    output logic target_port_enable,
    output logic ctrl_irq,
    output logic tgt_tx_irq,
    output logic tgt_rx_second_irq,
    output logic tgt_rx_first_irq
);
    import i2c_setup_pkg::*;

    byte_fifo_if #(.WIDTH(8)) rxq ();

    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_rx_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .port(rxq.fifo)
    );

    byte_t controller_shift_data, next_shift_data;
    byte_t target_address_reg, next_address_reg;
    logic [3:0] irq_enable, next_irq_enable;
    logic [2:0] tgt_flags, next_tgt_flags;
    logic ctrl_flag, next_ctrl_flag;
    logic rx_loaded, next_rx_loaded;
    logic next_pready, next_pslverr, next_resume_tx, next_resume_rx;
    logic [3:0] next_irqs;
    word_t next_prdata;
    logic access, wr, rd, hit_csd, hit_tar, hit_tcr, hit_cst, mapped, load;
    logic csd_busy;
    byte_t tcr_view;

    // Byte addresses are four times the register index
    always_comb
    begin
        access = psel && penable && pready;
        wr = access && pwrite;
        rd = access && !pwrite;
        hit_csd = paddr == {`CSD_IDX, 2'b00};
        hit_tar = paddr == {`TAR_IDX, 2'b00};
        hit_tcr = paddr == {`TCR_IDX, 2'b00};
        hit_cst = paddr == {`CST_IDX, 2'b00};
        mapped = hit_csd || hit_tar || hit_tcr || hit_cst;
        tcr_view = {irq_enable, 1'b0, tgt_flags};
        // No load during any shift-data access: a byte landing after the read
        // data was captured would be freed unseen by that same read
        csd_busy = psel && hit_csd;
        // A waiting byte holds the FIFO, so the bus side sees back-pressure
        load = rxq.out_valid && !rx_loaded && !csd_busy;
    end

    always_comb
    begin
        rxq.in_data = rx_byte;
        rxq.in_valid = rx_byte_valid;
        rxq.out_ready = !rx_loaded && !csd_busy;
    end

    // One wait state: pready rises in the second access cycle
    always_comb
    begin
        next_pready = psel && penable && !pready;
        next_pslverr = next_pready && !mapped;
        next_prdata = '0;
        if (next_pready && !pwrite)
        begin
            if (hit_csd)
                next_prdata[7:0] = controller_shift_data;
            else if (hit_tar)
                next_prdata[7:0] = target_address_reg;
            else if (hit_tcr)
                next_prdata[7:0] = tcr_view;
            else if (hit_cst)
                next_prdata[`CTRL_FLAG_BIT] = ctrl_flag;
        end
    end

    always_comb
    begin
        next_shift_data = controller_shift_data;
        next_rx_loaded = rx_loaded;
        next_resume_tx = 1'b0;
        next_resume_rx = 1'b0;
        if (wr && hit_csd)
        begin
            next_shift_data = pwdata[7:0];
            next_resume_tx = transfer_open;
        end
        else if (load)
        begin
            next_shift_data = rxq.out_data;
            next_rx_loaded = 1'b1;
        end
        if (rd && hit_csd)
        begin
            next_resume_rx = transfer_open;
            next_rx_loaded = 1'b0;
        end
    end

    always_comb
    begin
        next_address_reg = target_address_reg;
        next_irq_enable = irq_enable;
        if (wr && hit_tar)
            next_address_reg = pwdata[7:0];
        if (wr && hit_tcr)
            next_irq_enable = pwdata[`CTRL_IE_BIT:`RX1_IE_BIT];
    end

    // Write of zero clears a flag; a same-cycle hardware event wins
    always_comb
    begin
        next_tgt_flags = tgt_flags;
        next_ctrl_flag = ctrl_flag;
        if (wr && hit_tcr)
            next_tgt_flags = tgt_flags & pwdata[`TX_FLAG_BIT:`RX1_FLAG_BIT];
        if (wr && hit_cst)
            next_ctrl_flag = ctrl_flag & pwdata[`CTRL_FLAG_BIT];
        if (tgt_tx_done)
            next_tgt_flags[`TX_FLAG_BIT] = 1'b1;
        if (tgt_rx_second_done)
            next_tgt_flags[`RX2_FLAG_BIT] = 1'b1;
        if (tgt_rx_first_done)
            next_tgt_flags[`RX1_FLAG_BIT] = 1'b1;
        if (ctrl_byte_done)
            next_ctrl_flag = 1'b1;
        // Built from next values so requests track flags without lag
        next_irqs = {next_ctrl_flag, next_tgt_flags} & next_irq_enable;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            controller_shift_data <= `CSD_RST;
            target_address_reg <= `TAR_RST;
            irq_enable <= 4'(`TCR_RST >> `RX1_IE_BIT);
            tgt_flags <= 3'(`TCR_RST);
            ctrl_flag <= 1'(`CST_RST);
            rx_loaded <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
            resume_tx <= 1'b0;
            resume_rx <= 1'b0;
            {ctrl_irq, tgt_tx_irq, tgt_rx_second_irq, tgt_rx_first_irq} <= '0;
        end
        else
        begin
            controller_shift_data <= next_shift_data;
            target_address_reg <= next_address_reg;
            irq_enable <= next_irq_enable;
            tgt_flags <= next_tgt_flags;
            ctrl_flag <= next_ctrl_flag;
            rx_loaded <= next_rx_loaded;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            resume_tx <= next_resume_tx;
            resume_rx <= next_resume_rx;
            {ctrl_irq, tgt_tx_irq, tgt_rx_second_irq, tgt_rx_first_irq} <= next_irqs;
        end
    end

    assign tx_byte = controller_shift_data;
    assign own_target_address = target_address_reg[7:1];
    assign target_port_enable = target_address_reg[`TAR_EN_BIT];
    assign rx_byte_ready = rxq.in_ready;

    sequence apb_wait_s;
        psel && penable && !pready;
    endsequence

    sequence apb_done_s;
        pready ##1 !pready;
    endsequence

    property apb_one_wait_p;
        @(posedge clock) disable iff (!rst_b)
        apb_wait_s |=> apb_done_s;
    endproperty

    chk_apb_wait_state: assert property (apb_one_wait_p)
        else $error("pready did not follow one wait cycle");

    chk_resume_tx_write: assert property (@(posedge clock) disable iff (!rst_b)
        wr && hit_csd && transfer_open |=> resume_tx && tx_byte == $past(pwdata[7:0]) ##1 !resume_tx)
        else $error("write of shift data did not resume transmission");

    chk_resume_rx_read: assert property (@(posedge clock) disable iff (!rst_b)
        rd && hit_csd && transfer_open |=> resume_rx ##1 !resume_rx)
        else $error("read of shift data did not resume reception");

    chk_no_resume_closed: assert property (@(posedge clock) disable iff (!rst_b)
        !transfer_open |=> !resume_tx && !resume_rx)
        else $error("resume pulse outside a transfer");

    chk_target_addr_write: assert property (@(posedge clock) disable iff (!rst_b)
        wr && hit_tar |=> own_target_address == $past(pwdata[7:1])
        && target_port_enable == $past(pwdata[0]))
        else $error("target address or enable not stored");

    chk_ctrl_irq_gate: assert property (@(posedge clock) disable iff (!rst_b)
        ctrl_irq == (ctrl_flag && irq_enable[3]))
        else $error("controller request disagrees with flag and enable");

    chk_target_irq_gate: assert property (@(posedge clock) disable iff (!rst_b)
        {tgt_tx_irq, tgt_rx_second_irq, tgt_rx_first_irq} == (tgt_flags & irq_enable[2:0]))
        else $error("target request disagrees with flag and enable");

    chk_set_beats_clear: assert property (@(posedge clock) disable iff (!rst_b)
        tgt_tx_done |=> tgt_flags[`TX_FLAG_BIT] && tgt_tx_irq == irq_enable[2])
        else $error("transmit done event lost");

    chk_zero_clears_flag: assert property (@(posedge clock) disable iff (!rst_b)
        wr && hit_cst && !pwdata[0] && !ctrl_byte_done |=> !ctrl_flag ##1 !ctrl_irq || ctrl_flag)
        else $error("controller flag not cleared by zero");

    chk_rx_flags_set: assert property (@(posedge clock) disable iff (!rst_b)
        tgt_rx_second_done || tgt_rx_first_done
        |=> (tgt_flags[`RX2_FLAG_BIT] || !$past(tgt_rx_second_done))
        && (tgt_flags[`RX1_FLAG_BIT] || !$past(tgt_rx_first_done)))
        else $error("receive flag not set");

    chk_rx_hold: assert property (@(posedge clock) disable iff (!rst_b)
        rx_loaded && !(rd && hit_csd) |=> rx_loaded && $stable(controller_shift_data)
        || $past(wr && hit_csd))
        else $error("waiting received byte overwritten");

    sequence one_cycle_s(sig);
        sig ##1 !sig;
    endsequence

    chk_pready_single: assert property (@(posedge clock) disable iff (!rst_b)
        pready |-> one_cycle_s(pready))
        else $error("pready stood longer than one cycle");

    chk_unmapped_err: assert property (@(posedge clock) disable iff (!rst_b)
        pslverr |-> pready && prdata == '0)
        else $error("pslverr outside an answer or with data");

    chk_prdata_idle: assert property (@(posedge clock) disable iff (!rst_b)
        !pready |-> prdata == '0)
        else $error("read data outside an answer");

    chk_enable_write: assert property (@(posedge clock) disable iff (!rst_b)
        wr && hit_tcr |=> irq_enable == $past(pwdata[`CTRL_IE_BIT:`RX1_IE_BIT]))
        else $error("interrupt enables not stored");

    chk_tgt_flag_clear: assert property (@(posedge clock) disable iff (!rst_b)
        wr && hit_tcr && !tgt_tx_done && !pwdata[`TX_FLAG_BIT] |=> !tgt_flags[`TX_FLAG_BIT])
        else $error("target transmit flag not cleared by zero");

    chk_ctrl_flag_set: assert property (@(posedge clock) disable iff (!rst_b)
        ctrl_byte_done |=> ctrl_flag && ctrl_irq == irq_enable[3])
        else $error("controller byte done event lost");

    chk_irq_drop: assert property (@(posedge clock) disable iff (!rst_b)
        wr && hit_tcr && !pwdata[`CTRL_IE_BIT] |=> !ctrl_irq)
        else $error("controller request stood after its enable cleared");

    chk_rx_load: assert property (@(posedge clock) disable iff (!rst_b)
        load |=> rx_loaded && controller_shift_data == $past(rxq.out_data))
        else $error("received byte not moved into shift data");

    chk_reset_values: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rst_b) |-> controller_shift_data == `CSD_RST
        && own_target_address == `OWN_ADDR_RST && !target_port_enable
        && irq_enable == '0)
        else $error("register not at its reset value");
endmodule // i2c_setup

// File: far_end.sv
// Far-side model: bus-controller events and the received byte stream
module far_end (
    input wire logic clock,
    input wire logic rx_byte_ready,
    output logic transfer_open,
    output logic [3:0] ev,
    output i2c_setup_pkg::byte_t rx_byte,
    output logic rx_byte_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_setup_pkg::*;
    initial
    begin
        transfer_open = 1'b0;
        ev = 4'h0;
        rx_byte = 8'h00;
        rx_byte_valid = 1'b0;
    end
    task automatic pulse(input int i);
        @(posedge clock);
        ev[i] <= 1'b1;
        @(posedge clock);
        ev <= 4'h0;
    endtask
    task automatic set_open(input logic v);
        transfer_open <= v;
    endtask
    // Released line shows the inverse, so a stale byte cannot pass as fresh
    task automatic send(input byte_t b, output bit ok);
        ok = 0;
        @(posedge clock);
        rx_byte <= b;
        rx_byte_valid <= 1'b1;
        for (int n = 0; n < 30 && !ok; n++)
        begin
            @(posedge clock);
            ok = rx_byte_ready === 1'b1;
        end
        rx_byte_valid <= 1'b0;
        rx_byte <= ~b;
    endtask
endmodule // far_end

// File: tb_top.sv
// Self-checking bench for the I2C setup register block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_setup_pkg::*;
    typedef struct {apb_addr_t a; byte_t d; byte_t e;} row_t;
    logic clock, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic rx_byte_ready, rx_byte_valid, transfer_open, resume_tx, resume_rx;
    logic target_port_enable;
    logic [6:0] own_target_address;
    logic [3:0] m;
    wire [3:0] ev, irq;
    apb_addr_t paddr;
    word_t pwdata, prdata, rd;
    byte_t rx_byte, tx_byte;
    int n_errors = 0;
    int checks_done = 0;
    bit ok;
    // Write d, then read back e
    row_t rows[4] = '{
        '{12'h3A4, 8'hA5, 8'hA5},
        '{12'h3A8, 8'hF7, 8'hF4},
        '{12'h3A8, 8'h00, 8'h00},
        '{12'h388, 8'h3C, 8'h3C}};
    i2c_setup dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .transfer_open(transfer_open),
        .ctrl_byte_done(ev[3]), .tgt_tx_done(ev[2]), .tgt_rx_second_done(ev[1]),
        .tgt_rx_first_done(ev[0]), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
        .rx_byte_ready(rx_byte_ready), .tx_byte(tx_byte), .resume_tx(resume_tx),
        .resume_rx(resume_rx), .own_target_address(own_target_address),
        .target_port_enable(target_port_enable), .ctrl_irq(irq[3]),
        .tgt_tx_irq(irq[2]), .tgt_rx_second_irq(irq[1]), .tgt_rx_first_irq(irq[0]));
    far_end far (.clock(clock), .rx_byte_ready(rx_byte_ready),
        .transfer_open(transfer_open), .ev(ev), .rx_byte(rx_byte),
        .rx_byte_valid(rx_byte_valid));
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string name, input word_t exp, input word_t got);
        checks_done++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask
    task automatic apb(input logic w, input apb_addr_t a, input byte_t d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        ok = 0;
        for (int n = 0; n < 20 && !ok; n++)
        begin
            @(posedge clock);
            ok = pready === 1'b1;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok)
        begin
            n_errors++;
            report_and_stop();
        end
    endtask
    task automatic rdchk(input apb_addr_t a, input byte_t e);
        apb(1'b0, a, 8'h00);
        chk($sformatf("read %h", a), word_t'(e), rd);
    endtask
    task automatic settle();
        @(posedge clock);
        #1;
    endtask
    initial
    begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].e);
        end
        chk("own_target_address", 32'h52, word_t'(own_target_address));
        chk("target_port_enable", 32'h1, word_t'(target_port_enable));
        apb(1'b1, 12'h3FC, 8'hFF);
        chk("pslverr", 32'h1, word_t'(err));
        rdchk(12'h3FC, 8'h00);
        // Both directions, with the bus transfer closed and open
        for (int k = 0; k < 4; k++)
        begin
            far.set_open(k[1]);
            apb(k[0], 12'h388, 8'hA1);
            #1;
            chk("resume_tx", word_t'(k == 3), word_t'(resume_tx));
            chk("resume_rx", word_t'(k == 2), word_t'(resume_rx));
            settle();
            chk("resume", 32'h0, word_t'({resume_tx, resume_rx}));
        end
        far.set_open(1'b0);
        chk("tx_byte", 32'hA1, word_t'(tx_byte));
        apb(1'b1, 12'h3A8, 8'hF0);
        m = 4'h0;
        for (int i = 3; i >= 0; i--)
        begin
            far.pulse(i);
            #1;
            m = m | (4'h1 << i);
            chk("irq", word_t'(m), word_t'(irq));
        end
        rdchk(12'h3A8, 8'hF7);
        rdchk(12'h390, 8'h01);
        apb(1'b1, 12'h3A8, 8'h07);
        settle();
        chk("irq", 32'h0, word_t'(irq));
        apb(1'b1, 12'h3A8, 8'h80);
        rdchk(12'h3A8, 8'h80);
        chk("irq", 32'h8, word_t'(irq));
        apb(1'b1, 12'h390, 8'h00);
        settle();
        chk("irq", 32'h0, word_t'(irq));
        // Transmit-done event on the edge that applies a clearing write: set wins
        fork
            apb(1'b1, 12'h3A8, 8'hC0);
            begin
                repeat (2) @(posedge clock);
                far.pulse(2);
            end
        join
        rdchk(12'h3A8, 8'hC4);
        chk("irq", 32'h4, word_t'(irq));
        rst_b <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        rdchk(12'h388, 8'h00);
        rdchk(12'h3A4, 8'hC8);
        rdchk(12'h3A8, 8'h04);
        rdchk(12'h390, 8'h00);
        // Slot plus four queued bytes, then the stream must stall
        for (int i = 0; i < 5; i++)
        begin
            far.send(byte_t'(8'h11 + i), ok);
            chk("rx accepted", 32'h1, word_t'(ok));
        end
        settle();
        settle();
        chk("rx_byte_ready", 32'h0, word_t'(rx_byte_ready));
        for (int i = 0; i < 5; i++)
            rdchk(12'h388, byte_t'(8'h11 + i));
        chk("rx_byte_ready", 32'h1, word_t'(rx_byte_ready));
        report_and_stop();
    end
endmodule // tb_top
